// >>> hw/brcf_ret_stack.sv
// Return-address store for the subroutine call and return logic.
// Assumes one clock; the caller never reads and writes the same word in one cycle.
`timescale 1ns/1ns
`default_nettype none

module brcf_ret_stack #(
	parameter int ADDR_BITS = 3,
	parameter int DATA_BITS = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic writeEn,
	input wire logic [ADDR_BITS-1:0] writeAddr,
	input wire logic [DATA_BITS-1:0] writeData,
	input wire logic readEn,
	input wire logic [ADDR_BITS-1:0] readAddr,
	output logic [DATA_BITS-1:0] readData
);
	// ==========================================================
	// Storage
	logic [DATA_BITS-1:0] mem [0:(1<<ADDR_BITS)-1];

	// Write port, no reset on the array itself
	always_ff @(posedge clk)
	begin
		if (writeEn)
		begin
			mem[writeAddr] <= writeData;
		end
	end

	// Registered read port
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			readData <= '0;
		end
		else if (readEn)
		begin
			readData <= mem[readAddr];
		end
	end
endmodule : brcf_ret_stack

`default_nettype wire

// >>> hw/brcf_core.sv
// Branch condition evaluation and control-flow decode, with its constants package.
// Assumes fetch supplies decoded operation class, condition field, flags and addresses.
//
// Operation
// - A conditional branch goes to its target only when its flag condition is true.
// - Always/never ignore flags; higher/lower-same test C or Z; equal tests Z; V and N forms test V and N.
// - Carry-clear branches when C is 0 and carry-set branches when C is 1.
// - Signed forms test N xor V, and Z or (N xor V) for greater-than and less-or-equal.
// - A jump always loads the program counter with its target, with no flag test.
// - Relative and absolute calls go to the subroutine and save the return point unless all 8 store entries are full.
// - A return restores the saved return point and resumes after the original call; with the store empty it falls through to nextPc.
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Package
package brcf_pkg;
	localparam int ADDR_W = 16;
	localparam int STACK_AW = 3;
	localparam logic [STACK_AW:0] STACK_DEPTH = 4'h8;
	localparam logic [STACK_AW:0] SP_RESET = 4'h0;
	localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam int BITNUM_LSB = 4;
	localparam int BITNUM_W = 3;

	// Condition field codes
	localparam logic [3:0] CC_ALWAYS = 4'h0;
	localparam logic [3:0] CC_NEVER = 4'h1;
	localparam logic [3:0] CC_HI = 4'h2;
	localparam logic [3:0] CC_LS = 4'h3;
	localparam logic [3:0] CC_HS = 4'h4;
	localparam logic [3:0] CC_LO = 4'h5;
	localparam logic [3:0] CC_NE = 4'h6;
	localparam logic [3:0] CC_EQ = 4'h7;
	localparam logic [3:0] CC_VC = 4'h8;
	localparam logic [3:0] CC_VS = 4'h9;
	localparam logic [3:0] CC_PL = 4'hA;
	localparam logic [3:0] CC_MI = 4'hB;
	localparam logic [3:0] CC_GE = 4'hC;
	localparam logic [3:0] CC_LT = 4'hD;
	localparam logic [3:0] CC_GT = 4'hE;
	localparam logic [3:0] CC_LE = 4'hF;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_BRANCH = 3'h1,
		OP_JUMP = 3'h2,
		OP_CALL_REL = 3'h3,
		OP_CALL_ABS = 3'h4,
		OP_RETURN = 3'h5,
		OP_BITOP = 3'h6
	} brcf_op_type;

	typedef enum logic [0:0] {
		ST_IDLE = 1'h0,
		ST_RETWAIT = 1'h1
	} brcf_state_type;

	typedef struct packed {
		brcf_state_type state;
		logic [STACK_AW:0] sp;
		logic busy;
		logic pcLoad;
		logic [ADDR_W-1:0] pcValue;
		logic branchTaken;
		logic bitValid;
		logic [7:0] bitMask;
		logic stackFault;
	} brcf_regs_type;

	// Flag condition of a branch
	function automatic logic condTrue(input logic [3:0] cc, input logic c, input logic z,
		input logic v, input logic n);
		logic t;
		t = 1'b0;
		case (cc)
			CC_ALWAYS: t = 1'b1;
			CC_NEVER: t = 1'b0;
			CC_HI: t = ((c | z) == 1'b0);
			CC_LS: t = ((c | z) == 1'b1);
			CC_HS: t = (c == 1'b0);
			CC_LO: t = (c == 1'b1);
			CC_NE: t = (z == 1'b0);
			CC_EQ: t = (z == 1'b1);
			CC_VC: t = (v == 1'b0);
			CC_VS: t = (v == 1'b1);
			CC_PL: t = (n == 1'b0);
			CC_MI: t = (n == 1'b1);
			CC_GE: t = ((n ^ v) == 1'b0);
			CC_LT: t = ((n ^ v) == 1'b1);
			CC_GT: t = ((z | (n ^ v)) == 1'b0);
			CC_LE: t = ((z | (n ^ v)) == 1'b1);
			default: t = 1'b0;
		endcase
		return t;
	endfunction : condTrue

	// One-hot mask from the immediate bit number
	function automatic logic [7:0] bitSelect(input logic [BITNUM_W-1:0] num);
		return 8'h01 << num;
	endfunction : bitSelect
endpackage : brcf_pkg

module brcf_core (
	input wire logic clk,
	input wire logic nrst,
	input wire logic instrValid,
	input wire brcf_pkg::brcf_op_type instrOp,
	input wire logic [3:0] condCode,
	input wire logic [15:0] instrWord,
	input wire logic [brcf_pkg::ADDR_W-1:0] nextPc,
	input wire logic [brcf_pkg::ADDR_W-1:0] relDisp,
	input wire logic [brcf_pkg::ADDR_W-1:0] absTarget,
	input wire logic flagC,
	input wire logic flagZ,
	input wire logic flagV,
	input wire logic flagN,
	output logic pcLoad,
	output logic [brcf_pkg::ADDR_W-1:0] pcValue,
	output logic branchTaken,
	output logic bitValid,
	output logic [7:0] bitMask,
	output logic busy,
	output logic stackFault
);
	import brcf_pkg::*;

	brcf_regs_type r;
	brcf_regs_type next_r;
	logic accept;
	logic [ADDR_W-1:0] relTarget;
	logic pushEn;
	logic popEn;
	logic [STACK_AW-1:0] popAddr;
	logic [ADDR_W-1:0] retData;

	// ==========================================================
	// Request decode
	assign accept = instrValid && !r.busy;
	assign relTarget = ADDR_W'(nextPc + relDisp); // Wraps modulo the address space
	assign pushEn = accept && (instrOp == OP_CALL_REL || instrOp == OP_CALL_ABS)
		&& (r.sp != STACK_DEPTH);
	assign popEn = accept && (instrOp == OP_RETURN) && (r.sp != SP_RESET);
	assign popAddr = STACK_AW'(r.sp - 4'h1);

	// Return-point store
	brcf_ret_stack #(
		.ADDR_BITS(STACK_AW),
		.DATA_BITS(ADDR_W)
	) u_stack (
		.clk(clk),
		.nrst(nrst),
		.writeEn(pushEn),
		.writeAddr(r.sp[STACK_AW-1:0]),
		.writeData(nextPc),
		.readEn(popEn),
		.readAddr(popAddr),
		.readData(retData)
	);

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		next_r = r;
		next_r.pcLoad = 1'b0;
		next_r.branchTaken = 1'b0;
		next_r.bitValid = 1'b0;
		next_r.stackFault = 1'b0;
		case (r.state)
			ST_IDLE:
			begin
				if (accept)
				begin
					case (instrOp)
						OP_BRANCH:
						begin
							next_r.pcLoad = 1'b1;
							if (condTrue(condCode, flagC, flagZ, flagV, flagN))
							begin
								next_r.pcValue = relTarget;
								next_r.branchTaken = 1'b1;
							end
							else
							begin
								next_r.pcValue = nextPc;
							end
						end
						OP_JUMP:
						begin
							next_r.pcLoad = 1'b1;
							next_r.pcValue = absTarget;
							next_r.branchTaken = 1'b1;
						end
						OP_CALL_REL, OP_CALL_ABS:
						begin
							next_r.pcLoad = 1'b1;
							next_r.branchTaken = 1'b1;
							next_r.pcValue = (instrOp == OP_CALL_REL) ? relTarget : absTarget;
							if (pushEn)
							begin
								next_r.sp = r.sp + 4'h1;
							end
							else
							begin
								next_r.stackFault = 1'b1; // Store full, return point lost
							end
						end
						OP_RETURN:
						begin
							if (popEn)
							begin
								next_r.sp = r.sp - 4'h1;
								next_r.state = ST_RETWAIT;
								next_r.busy = 1'b1;
							end
							else
							begin
								next_r.pcLoad = 1'b1; // Empty store: fall through
								next_r.pcValue = nextPc;
								next_r.stackFault = 1'b1;
							end
						end
						OP_BITOP:
						begin
							next_r.bitValid = 1'b1;
							next_r.bitMask = bitSelect(instrWord[BITNUM_LSB +: BITNUM_W]);
						end
						default:
						begin
							next_r.pcLoad = 1'b0;
						end
					endcase
				end
			end
			ST_RETWAIT:
			begin
				next_r.pcLoad = 1'b1;
				next_r.pcValue = retData;
				next_r.branchTaken = 1'b1;
				next_r.state = ST_IDLE;
				next_r.busy = 1'b0;
			end
			default:
			begin
				next_r.state = ST_IDLE;
				next_r.busy = 1'b0;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			r <= '{state: ST_IDLE, sp: SP_RESET, busy: 1'b0, pcLoad: 1'b0, pcValue: PC_RESET,
				branchTaken: 1'b0, bitValid: 1'b0, bitMask: MASK_RESET, stackFault: 1'b0};
		end
		else
		begin
			r <= next_r;
		end
	end

	// Outputs straight from the state register
	assign pcLoad = r.pcLoad;
	assign pcValue = r.pcValue;
	assign branchTaken = r.branchTaken;
	assign bitValid = r.bitValid;
	assign bitMask = r.bitMask;
	assign busy = r.busy;
	assign stackFault = r.stackFault;

	// ==========================================================
	// Assertions
	sequence s_take(logic [3:0] cc);
		accept && instrOp == OP_BRANCH && condCode == cc;
	endsequence

	sequence s_ret_issue;
		accept && instrOp == OP_RETURN && r.sp != SP_RESET;
	endsequence

	property p_branch_true;
		@(posedge clk) disable iff (!nrst)
		accept && instrOp == OP_BRANCH && condTrue(condCode, flagC, flagZ, flagV, flagN)
		|=> pcLoad && branchTaken && pcValue == $past(nextPc) + $past(relDisp);
	endproperty
	a_branch_true: assert property (p_branch_true) else $error("taken branch wrong");

	property p_higher;
		@(posedge clk) disable iff (!nrst)
		s_take(CC_HI) ##0 (flagC || flagZ) |=> pcLoad && !branchTaken;
	endproperty
	a_higher: assert property (p_higher) else $error("higher taken with C or Z");

	property p_carry_clear;
		@(posedge clk) disable iff (!nrst)
		s_take(CC_HS) ##0 !flagC |=> branchTaken;
	endproperty
	a_carry_clear: assert property (p_carry_clear) else $error("carry clear not taken");

	property p_signed_less;
		@(posedge clk) disable iff (!nrst)
		s_take(CC_LT) ##0 (flagN ^ flagV) |=> branchTaken;
	endproperty
	a_signed_less: assert property (p_signed_less) else $error("less-than not taken");

	property p_jump;
		@(posedge clk) disable iff (!nrst)
		accept && instrOp == OP_JUMP |=> pcLoad && branchTaken && pcValue == $past(absTarget);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target wrong");

	property p_call;
		@(posedge clk) disable iff (!nrst)
		accept && instrOp == OP_CALL_ABS && r.sp != STACK_DEPTH
		|=> pcValue == $past(absTarget) && r.sp == $past(r.sp) + 4'h1;
	endproperty
	a_call: assert property (p_call) else $error("call did not save return point");

	property p_return;
		@(posedge clk) disable iff (!nrst)
		s_ret_issue |=> busy && !pcLoad ##1 pcLoad && branchTaken && !busy;
	endproperty
	a_return: assert property (p_return) else $error("return timing wrong");

	property p_bit_select;
		@(posedge clk) disable iff (!nrst)
		accept && instrOp == OP_BITOP
		|=> bitValid && $onehot(bitMask)
		&& bitMask == bitSelect($past(instrWord[BITNUM_LSB +: BITNUM_W]));
	endproperty
	a_bit_select: assert property (p_bit_select) else $error("bit mask wrong");

	property p_not_taken;
		@(posedge clk) disable iff (!nrst)
		accept && instrOp == OP_BRANCH && !condTrue(condCode, flagC, flagZ, flagV, flagN)
		|=> pcLoad && !branchTaken && pcValue == $past(nextPc) && r.sp == $past(r.sp);
	endproperty
	a_not_taken: assert property (p_not_taken) else $error("false branch wrong");
endmodule : brcf_core

`default_nettype wire

// >>> bench/tb_branch_condition_and_control_flow.sv
// Self-checking bench for the branch condition and control-flow core.
// Assumes brcf_pkg and brcf_core are compiled first; one 100 MHz clock, no partner.
`timescale 1ns/1ns
`default_nettype none

module tb_branch_condition_and_control_flow;
	import brcf_pkg::*;

	typedef struct packed {
		logic [1:0] kind;
		logic [15:0] val;
		logic taken;
		logic fault;
	} brcf_exp_type;

	`define CHK(nm, ex, got) \
		begin \
			testsRun++; \
			if ((got) !== (ex)) \
			begin \
				nErrors++; \
				$display("BAD %s expected %0h seen %0h", nm, ex, got); \
			end \
		end

	// ==========================================================
	// Signals
	logic clk, nrst, instrValid, flagC, flagZ, flagV, flagN;
	brcf_op_type instrOp, op;
	logic [3:0] condCode;
	logic [15:0] instrWord, nextPc, relDisp, absTarget, pcValue;
	logic pcLoad, branchTaken, bitValid, busy, stackFault, tk;
	logic [7:0] bitMask;
	logic [31:0] seed = 32'h0000612D;
	int nErrors = 0;
	int testsRun = 0;
	brcf_exp_type expQ[$];
	brcf_exp_type e;
	logic [15:0] retStack[$];

	brcf_core uut (.clk(clk), .nrst(nrst), .instrValid(instrValid), .instrOp(instrOp),
		.condCode(condCode), .instrWord(instrWord), .nextPc(nextPc), .relDisp(relDisp),
		.absTarget(absTarget), .flagC(flagC), .flagZ(flagZ), .flagV(flagV), .flagN(flagN),
		.pcLoad(pcLoad), .pcValue(pcValue), .branchTaken(branchTaken), .bitValid(bitValid),
		.bitMask(bitMask), .busy(busy), .stackFault(stackFault));

	// Clock generation
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Expected branch decision; odd codes are the true sense of each pair
	function automatic logic expCond(input logic [3:0] cc, input logic [3:0] f);
		logic t;
		case (cc[3:1])
			3'h0: t = 1'b0;
			3'h1: t = f[3] | f[2];
			3'h2: t = f[3];
			3'h3: t = f[2];
			3'h4: t = f[1];
			3'h5: t = f[0];
			3'h6: t = f[0] ^ f[1];
			default: t = f[2] | (f[0] ^ f[1]);
		endcase
		return cc[0] ? t : ~t;
	endfunction : expCond

	// Random operands; a non-negative flag set or bit number replaces the random one
	task automatic randAll(input int fl = -1, input int bn = -1);
		logic [31:0] r;
		logic [31:0] s;
		logic [15:0] w;
		r = rnd();
		s = rnd();
		w = s[31:16];
		if (bn >= 0)
			w[BITNUM_LSB +: BITNUM_W] = bn[BITNUM_W-1:0];
		nextPc = r[15:0];
		relDisp = r[31:16];
		absTarget = s[15:0];
		instrWord = w;
		if (fl >= 0)
			{flagC, flagZ, flagV, flagN} = fl[3:0];
		else
			{flagC, flagZ, flagV, flagN} = s[3:0];
	endtask : randAll

	// Instruction presented for one edge; valid stays up so a successor can follow at once
	task automatic issue(input brcf_op_type o, input logic [3:0] cc);
		instrOp = o;
		condCode = cc;
		instrValid = 1'b1;
		@(posedge clk);
		#1;
	endtask : issue

	task automatic stopTest();
		$display("checks %0d errors %0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stopTest

	// ==========================================================
	// Monitor: each result pulse consumes the oldest expectation
	always @(posedge clk)
	begin
		#2;
		if (nrst && (pcLoad === 1'b1 || bitValid === 1'b1 || stackFault === 1'b1))
		begin
			if (expQ.size() == 0)
			begin
				nErrors++;
				$display("BAD result expected none seen pulse");
			end
			else
			begin
				e = expQ.pop_front();
				`CHK("pcLoad", e.kind == 2'd0, pcLoad)
				`CHK("bitValid", e.kind == 2'd1, bitValid)
				`CHK("stackFault", e.fault, stackFault)
				if (e.kind == 2'd1)
					`CHK("bitMask", e.val[7:0], bitMask)
				else
				begin
					`CHK("pcValue", e.val, pcValue)
					`CHK("branchTaken", e.taken, branchTaken)
				end
			end
		end
	end

	// Watchdog against a hang
	initial
	begin
		#(5000 * 10);
		nErrors++;
		$display("BAD watchdog expected done seen hang");
		stopTest();
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		nrst = 1'b0;
		instrValid = 1'b0;
		instrOp = OP_NONE;
		condCode = 4'h0;
		randAll();
		repeat (8) @(posedge clk);
		#1;
		nrst = 1'b1;
		// Every condition code against every flag combination, back to back
		for (int i = 0; i < 256; i++)
		begin
			randAll(i[3:0], -1);
			tk = expCond(i[7:4], i[3:0]);
			expQ.push_back('{2'd0, tk ? nextPc + relDisp : nextPc, tk, 1'b0});
			issue(OP_BRANCH, i[7:4]);
		end
		// Jumps ignore flags; empty slots give nothing
		for (int i = 0; i < 16; i++)
		begin
			randAll();
			expQ.push_back('{2'd0, absTarget, 1'b1, 1'b0});
			issue(OP_JUMP, i[3:0]);
			issue(OP_NONE, 4'h0);
		end
		// Every bit number
		for (int k = 0; k < 8; k++)
		begin
			randAll(-1, k);
			expQ.push_back('{2'd1, 16'h0001 << k, 1'b0, 1'b0});
			issue(OP_BITOP, 4'h0);
		end
		// Nine calls: the last one overflows the store
		for (int i = 0; i < 9; i++)
		begin
			randAll();
			op = i[0] ? OP_CALL_ABS : OP_CALL_REL;
			expQ.push_back('{2'd0, i[0] ? absTarget : nextPc + relDisp, 1'b1, i == 8});
			if (i < 8)
				retStack.push_back(nextPc);
			issue(op, 4'h0);
		end
		// Returns come back in reverse order; the ninth finds the store empty
		for (int i = 0; i < 9; i++)
		begin
			randAll();
			if (i < 8)
				expQ.push_back('{2'd0, retStack.pop_back(), 1'b1, 1'b0});
			else
				expQ.push_back('{2'd0, nextPc, 1'b0, 1'b1});
			issue(OP_RETURN, 4'h0);
			if (i < 8)
			begin
				`CHK("busy", 1'b1, busy)
				issue(OP_JUMP, 4'h0);
			end
		end
		instrValid = 1'b0;
		// Reset in mid-run: outputs clear and the store empties
		@(posedge clk);
		#1;
		nrst = 1'b0;
		@(posedge clk);
		#1;
		`CHK("pcValue", PC_RESET, pcValue)
		`CHK("bitMask", MASK_RESET, bitMask)
		`CHK("busy", 1'b0, busy)
		nrst = 1'b1;
		randAll(-1, -1);
		expQ.push_back('{2'd0, nextPc, 1'b0, 1'b1});
		issue(OP_RETURN, 4'h0);
		instrValid = 1'b0;
		repeat (4) @(posedge clk);
		`CHK("pending", 0, expQ.size())
		stopTest();
	end
endmodule : tb_branch_condition_and_control_flow

`default_nettype wire
